/* hdl/crw_core_regs.sv */
/*
  core register block: rom window, accumulator, pointers, short-direct
  registers, instruction pointer, banked carry/zero flags, return stack.
  assumes a sequencer drives one request per cycle and program memory
  answers rom_data combinationally for rom_addr.
*/
// Contract
// - window 40h-7Fh reads program memory
// - rom address is base then low six; code drops base bit six
// - base at C9h: plain writes only
// - base not reset, undefined until written
// - only base bits six..zero kept
// - accumulator mapped at FFh
// - pointers at 80h and 81h
// - short-direct registers at 82h, 83h
// - instruction pointer is twelve bits
// - pointer loads jump, vector, stack, else increments
// - relative branch adds signed offset
// - three carry/zero pairs per context
// - context switch selects pair, keeps values
// - only current context pair accessible
// - carry from arithmetic, bit test, rotate
// - zero reflects latest result
// - reset starts in nonmaskable context
// - six level stack pushes, drops sixth
// - return pops level one, shifts down
// - empty-stack return keeps stack, continues
`include "crw_defs.svh"
`default_nettype none
module crw_core_regs #(
  parameter logic [11:0] IRQ_VECTOR = 12'hFF0,
  parameter logic [11:0] NMI_VECTOR = 12'hFFC
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire logic                  clk_en,
  // data space access
  input  wire crw_pkg::crw_data_req_s data_req,
  output logic [7:0]                 data_rdata,
  output logic                       data_hit,
  // program memory for the window
  output logic [11:0]                rom_addr,
  input  wire logic [7:0]            rom_data,
  // sequencer
  input  wire crw_pkg::crw_pc_cmd_s  pc_cmd,
  input  wire crw_pkg::crw_flag_upd_s flag_upd,
  output logic [11:0]                instruction_pointer,
  output logic                       carry_flag,
  output logic                       zero_flag,
  output crw_pkg::crw_ctx_e          context_now
);
  typedef struct packed {
    logic [7:0]              acc;
    logic [7:0]              ptr_x;
    logic [7:0]              ptr_y;
    logic [7:0]              sd_first;
    logic [7:0]              sd_second;
    logic [6:0]              rom_window_page_bits;
    logic [11:0]             pc;
    logic [5:0][11:0]        stack;
    logic [2:0]              depth;
    crw_pkg::crw_flags_s     fl_norm;
    crw_pkg::crw_flags_s     fl_irq;
    crw_pkg::crw_flags_s     fl_nmi;
    crw_pkg::crw_ctx_e       ctx;
    crw_pkg::crw_ctx_e       ctx_prev;
    logic [7:0]              rdata;
    logic                    hit;
    logic [11:0]             rom_addr;
    logic                    cf;
    logic                    zf;
  } crw_state_s;

  crw_state_s st_r;
  crw_state_s st_nxt;
  logic       in_window;
  logic [11:0] rel_ext;

  assign in_window = (data_req.addr >= `CRW_WIN_LO) &&
                     (data_req.addr <= `CRW_WIN_HI);
  assign rel_ext = {{4{pc_cmd.offset[7]}}, pc_cmd.offset};

  always_comb begin
    st_nxt = st_r;
    st_nxt.hit = 1'b0;
    st_nxt.rdata = 8'h00;
    st_nxt.rom_addr = {st_r.rom_window_page_bits[5:0],
                       data_req.addr[`CRW_WIN_OFS_W-1:0]};
    if (data_req.rd) begin
      st_nxt.hit = 1'b1;
      if (in_window) begin
        st_nxt.rdata = rom_data;
      end else begin
        case (data_req.addr)
          `CRW_ADDR_ACC:      st_nxt.rdata = st_r.acc;
          `CRW_ADDR_PTR_X:    st_nxt.rdata = st_r.ptr_x;
          `CRW_ADDR_PTR_Y:    st_nxt.rdata = st_r.ptr_y;
          `CRW_ADDR_SD_FIRST: st_nxt.rdata = st_r.sd_first;
          `CRW_ADDR_SD_SEC:   st_nxt.rdata = st_r.sd_second;
          default:            st_nxt.hit = 1'b0;
        endcase
      end
    end
    if (data_req.wr) begin
      case (data_req.addr)
        `CRW_ADDR_ACC:      st_nxt.acc = data_req.wdata;
        `CRW_ADDR_PTR_X:    st_nxt.ptr_x = data_req.wdata;
        `CRW_ADDR_PTR_Y:    st_nxt.ptr_y = data_req.wdata;
        `CRW_ADDR_SD_FIRST: st_nxt.sd_first = data_req.wdata;
        `CRW_ADDR_SD_SEC:   st_nxt.sd_second = data_req.wdata;
        `CRW_ADDR_WIN_BASE: begin
          if (!data_req.bit_op) begin
            st_nxt.rom_window_page_bits = data_req.wdata[6:0];
          end
        end
        default: ;
      endcase
    end
    // carry from alu or bit test
    // only the live pair is written
    if (flag_upd.valid) begin
      case (st_r.ctx)
        crw_pkg::CRW_CTX_NORMAL: st_nxt.fl_norm = {flag_upd.carry,
                                                   flag_upd.zero};
        crw_pkg::CRW_CTX_IRQ:    st_nxt.fl_irq = {flag_upd.carry,
                                                  flag_upd.zero};
        default:                 st_nxt.fl_nmi = {flag_upd.carry,
                                                  flag_upd.zero};
      endcase
    end
    st_nxt.pc = st_r.pc + `CRW_PC_STEP;
    if (pc_cmd.valid) begin
      case (pc_cmd.op)
        crw_pkg::CRW_PC_JUMP: st_nxt.pc = pc_cmd.target;
        crw_pkg::CRW_PC_REL:  st_nxt.pc = st_r.pc + rel_ext;
        crw_pkg::CRW_PC_IRQ, crw_pkg::CRW_PC_NMI: begin
          st_nxt.pc = (pc_cmd.op == crw_pkg::CRW_PC_IRQ) ?
                      IRQ_VECTOR : NMI_VECTOR;
          st_nxt.stack = {st_r.stack[4:0], st_r.pc};
          if (st_r.depth != 3'(`CRW_STACK_DEPTH)) begin
            st_nxt.depth = st_r.depth + 3'h1;
          end
          st_nxt.ctx_prev = st_r.ctx;
          st_nxt.ctx = (pc_cmd.op == crw_pkg::CRW_PC_IRQ) ?
                       crw_pkg::CRW_CTX_IRQ : crw_pkg::CRW_CTX_NMI;
        end
        crw_pkg::CRW_PC_RET, crw_pkg::CRW_PC_RETURN_FROM_INTERRUPT: begin
          if (st_r.depth != 3'h0) begin
            st_nxt.pc = st_r.stack[0];
            st_nxt.stack = {12'h000, st_r.stack[5:1]};
            st_nxt.depth = st_r.depth - 3'h1;
          end
          if (pc_cmd.op == crw_pkg::CRW_PC_RETURN_FROM_INTERRUPT) begin
            st_nxt.ctx = st_r.ctx_prev;
            st_nxt.ctx_prev = crw_pkg::CRW_CTX_NORMAL;
          end
        end
        default: ;
      endcase
    end
    // call is JUMP with offset bit zero set, which also pushes the pointer; kept separate
    if (pc_cmd.valid && pc_cmd.op == crw_pkg::CRW_PC_JUMP &&
        pc_cmd.offset[0]) begin
      st_nxt.stack = {st_r.stack[4:0], st_r.pc};
      if (st_r.depth != 3'(`CRW_STACK_DEPTH)) begin
        st_nxt.depth = st_r.depth + 3'h1;
      end
    end
    case (st_nxt.ctx)
      crw_pkg::CRW_CTX_NORMAL: {st_nxt.cf, st_nxt.zf} = st_nxt.fl_norm;
      crw_pkg::CRW_CTX_IRQ:    {st_nxt.cf, st_nxt.zf} = st_nxt.fl_irq;
      default:                 {st_nxt.cf, st_nxt.zf} = st_nxt.fl_nmi;
    endcase
  end

  // window base and data regs outside reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r.ctx      <= crw_pkg::CRW_CTX_NMI;
      st_r.ctx_prev <= crw_pkg::CRW_CTX_NORMAL;
      st_r.pc       <= `CRW_RESET_VECTOR;
      st_r.depth    <= 3'h0;
      st_r.rdata    <= 8'h00;
      st_r.hit      <= 1'b0;
      st_r.rom_addr <= 12'h000;
      st_r.fl_norm  <= '0;
      st_r.fl_irq   <= '0;
      st_r.fl_nmi   <= '0;
      st_r.stack    <= '0;
      st_r.cf       <= 1'b0;
      st_r.zf       <= 1'b0;
    end else if (clk_en) begin
      st_r          <= st_nxt;
    end
  end

  // window address leaves combinationally for same-cycle rom answer
  assign rom_addr = st_nxt.rom_addr;

  assign carry_flag          = st_r.cf;
  assign zero_flag           = st_r.zf;
  assign data_rdata          = st_r.rdata;
  assign data_hit            = st_r.hit;
  assign instruction_pointer = st_r.pc;
  assign context_now         = st_r.ctx;
endmodule
`default_nettype wire

/* hdl/crw_defs.svh */
/*
  shared constants for the core register, stack and rom window block.
  assumes inclusion by bare name from hdl/.
*/
`ifndef CRW_DEFS_SVH
`define CRW_DEFS_SVH
`define CRW_WIN_LO        8'h40
`define CRW_WIN_HI        8'h7F
`define CRW_WIN_OFS_W     6
`define CRW_ADDR_PTR_X    8'h80
`define CRW_ADDR_PTR_Y    8'h81
`define CRW_ADDR_SD_FIRST 8'h82
`define CRW_ADDR_SD_SEC   8'h83
`define CRW_ADDR_WIN_BASE 8'hC9
`define CRW_ADDR_ACC      8'hFF
`define CRW_PAGE_W        7
`define CRW_PC_W          12
`define CRW_STACK_DEPTH   6
`define CRW_DEPTH_W       3
`define CRW_RESET_VECTOR  12'hFFE
`define CRW_PC_STEP       12'h001
`endif

/* hdl/crw_pkg.sv */
/*
  types for the core register block.
  assumes crw_defs.svh sits beside it.
*/
`include "crw_defs.svh"
`default_nettype none
package crw_pkg;
  typedef enum logic [1:0] {
    CRW_CTX_NORMAL,
    CRW_CTX_IRQ,
    CRW_CTX_NMI
  } crw_ctx_e;

  typedef struct packed {
    logic c;
    logic z;
  } crw_flags_s;

  typedef enum logic [2:0] {
    CRW_PC_SEQ,
    CRW_PC_JUMP,
    CRW_PC_REL,
    CRW_PC_IRQ,
    CRW_PC_NMI,
    CRW_PC_RET,
    CRW_PC_RETURN_FROM_INTERRUPT
  } crw_pc_op_e;

  typedef struct packed {
    logic       valid;
    crw_pc_op_e op;
    logic [11:0] target;
    logic [7:0]  offset;
  } crw_pc_cmd_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       bit_op;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crw_data_req_s;

  typedef struct packed {
    logic       valid;
    logic       carry;
    logic       zero;
  } crw_flag_upd_s;
endpackage
`default_nettype wire

/* bench/crw_core_regs_props.sv */
/*
  port assertions for the core register block.
  assumes it is bound to crw_core_regs.
*/
`default_nettype none
module crw_core_regs_props #(
  parameter logic [11:0] IRQ_VECTOR = 12'hFF0
) (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   arst_n,
  input wire logic                   clk_en,
  // data side
  input wire crw_pkg::crw_data_req_s data_req,
  input wire logic [7:0]             data_rdata,
  input wire logic                   data_hit,
  input wire logic [7:0]             rom_data,
  // sequencer side
  input wire crw_pkg::crw_pc_cmd_s   pc_cmd,
  input wire crw_pkg::crw_flag_upd_s flag_upd,
  input wire logic [11:0]            instruction_pointer,
  input wire logic                   carry_flag,
  input wire logic                   zero_flag,
  input wire crw_pkg::crw_ctx_e      context_now
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_win_rd;
    clk_en && data_req.rd && data_req.addr[7:6] == 2'h1
      |=> data_hit && data_rdata == $past(rom_data);
  endproperty
  a_win_rd: assert property (p_win_rd)
    else $error("window read wrong");
  property p_base_rd;
    clk_en && data_req.rd && data_req.addr == 8'hC9 |=> !data_hit;
  endproperty
  a_base_rd: assert property (p_base_rd)
    else $error("base register readable");
  property p_seq;
    clk_en && !pc_cmd.valid
      |=> instruction_pointer == $past(instruction_pointer) + 12'h001;
  endproperty
  a_seq: assert property (p_seq)
    else $error("pointer not incremented");
  property p_jump;
    clk_en && pc_cmd.valid && pc_cmd.op == crw_pkg::CRW_PC_JUMP
      |=> instruction_pointer == $past(pc_cmd.target);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target not loaded");
  property p_rel;
    clk_en && pc_cmd.valid && pc_cmd.op == crw_pkg::CRW_PC_REL
      |=> instruction_pointer == $past(instruction_pointer)
        + {{4{$past(pc_cmd.offset[7])}}, $past(pc_cmd.offset)};
  endproperty
  a_rel: assert property (p_rel)
    else $error("relative branch wrong");
  property p_irq;
    clk_en && pc_cmd.valid && pc_cmd.op == crw_pkg::CRW_PC_IRQ
      |=> instruction_pointer == IRQ_VECTOR
        && context_now == crw_pkg::CRW_CTX_IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt entry wrong");
  property p_flag;
    clk_en && flag_upd.valid && !pc_cmd.valid
      |=> carry_flag == $past(flag_upd.carry)
        && zero_flag == $past(flag_upd.zero);
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag pair not written");
  property p_reset;
    $rose(arst_n) |-> instruction_pointer == 12'hFFE
      && context_now == crw_pkg::CRW_CTX_NMI;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset state wrong");
endmodule
bind crw_core_regs crw_core_regs_props #(.IRQ_VECTOR(IRQ_VECTOR)) u_props (
  .clock, .arst_n, .clk_en, .data_req, .data_rdata, .data_hit, .rom_data,
  .pc_cmd, .flag_upd, .instruction_pointer, .carry_flag, .zero_flag,
  .context_now);
`default_nettype wire

/* bench/crw_rom_model.sv */
/*
  program memory model behind the rom window.
  assumes rom_addr from the core block.
*/
`default_nettype none
module crw_rom_model (
  // program memory port
  input  wire logic [11:0] rom_addr,
  output logic [7:0]       rom_data
);
  timeunit 1ns;
  timeprecision 1ps;
  assign rom_data = rom_addr[7:0] ^ {rom_addr[11:8], 4'h5};
endmodule
`default_nettype wire

/* bench/testbench.sv */
/*
  self-checking bench for the core register block.
  assumes crw_rom_model stands in for program memory.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clock, arst_n, clk_en, data_hit, carry_flag;
  logic                   zero_flag;
  logic [7:0]             data_rdata, rom_data, v;
  logic [11:0]            rom_addr, instruction_pointer, epc, t;
  logic [11:0]            stk[$];
  logic [7:0]             ra[5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
  crw_pkg::crw_data_req_s data_req;
  crw_pkg::crw_pc_cmd_s   pc_cmd;
  crw_pkg::crw_flag_upd_s flag_upd;
  crw_pkg::crw_ctx_e      context_now;
  int                     n_mismatch, checked;
  crw_core_regs dut (.clock, .arst_n, .clk_en, .data_req, .data_rdata,
    .data_hit, .rom_addr, .rom_data, .pc_cmd, .flag_upd,
    .instruction_pointer, .carry_flag, .zero_flag, .context_now);
  crw_rom_model mem (.rom_addr, .rom_data);
  function automatic logic [7:0] rom_exp(logic [7:0] b, logic [7:0] a);
    logic [11:0] p;
    p = {b[5:0], a[5:0]};
    return p[7:0] ^ {p[11:8], 4'h5};
  endfunction
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one request cycle, then idle; pointer moves once per cycle
  task automatic go(crw_pkg::crw_data_req_s d, crw_pkg::crw_pc_cmd_s c,
                    crw_pkg::crw_flag_upd_s f);
    @(posedge clock);
    data_req <= d;
    pc_cmd <= c;
    flag_upd <= f;
    @(posedge clock);
    data_req <= '0;
    pc_cmd <= '0;
    flag_upd <= '0;
    #1;
    epc = epc + 12'h001;
  endtask
  task automatic dacc(logic r, logic w, logic b, logic [7:0] a, d);
    go({r, w, b, a, d}, '0, '0);
    epc = epc + 12'h001;
  endtask
  task automatic pc(crw_pkg::crw_pc_op_e op, logic [11:0] tg, logic [7:0] o);
    go('0, {1'b1, op, tg, o}, '0);
    if (op == crw_pkg::CRW_PC_JUMP && o[0] || op == crw_pkg::CRW_PC_IRQ) begin
      stk.push_front(epc);
      if (stk.size() > 6) void'(stk.pop_back());
    end
    case (op)
      crw_pkg::CRW_PC_JUMP: epc = tg;
      crw_pkg::CRW_PC_IRQ: epc = 12'hFF0;
      crw_pkg::CRW_PC_REL: epc = epc + {{4{o[7]}}, o};
      default: epc = stk.size() > 0 ? stk.pop_front() : epc + 12'h001;
    endcase
    chk(instruction_pointer, epc);
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #20000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    {arst_n, clk_en, data_req, pc_cmd, flag_upd} = '0;
    clk_en = 1'b1;
    v = 8'($urandom(32'h7a26bace));
    repeat (6) @(posedge clock);
    chk({context_now, instruction_pointer}, 14'h2FFE);
    arst_n <= 1'b1;
    pc(crw_pkg::CRW_PC_JUMP, 12'h100, 8'h00);
    pc(crw_pkg::CRW_PC_RET, 12'h000, 8'h00);
    repeat (9) begin
      t = 12'($urandom);
      dacc(0, 1, 0, 8'hC9, v);
      dacc(1, 0, 0, {2'h1, t[5:0]}, 8'h00);
      chk({data_hit, data_rdata}, {1'b1, rom_exp(v, {2'h1, t[5:0]})});
      v = (t[11] ? t[7:0] : 8'h28);
    end
    dacc(0, 1, 0, 8'hC9, 8'h28);
    dacc(0, 1, 1, 8'hC9, 8'h15);
    dacc(1, 0, 0, 8'h59, 8'h00);
    chk(data_rdata, rom_exp(8'h28, 8'h59));
    dacc(1, 0, 0, 8'hC9, 8'h00);
    chk(data_hit, 1'b0);
    foreach (ra[i]) begin
      t = 12'($urandom);
      dacc(0, 1, 0, ra[i], t[7:0]);
      dacc(1, 0, 0, ra[i], 8'h00);
      chk({data_hit, data_rdata}, {1'b1, t[7:0]});
    end
    for (int i = 0; i < 7; i++) pc(crw_pkg::CRW_PC_JUMP, 12'(32 * i), 8'h01);
    for (int i = 0; i < 8; i++) pc(crw_pkg::CRW_PC_RET, 12'h000, 8'h00);
    pc(crw_pkg::CRW_PC_REL, 12'h000, t[7:0]);
    go('0, '0, 3'b110);
    epc = epc + 12'h001;
    chk({carry_flag, zero_flag}, 2'b10);
    pc(crw_pkg::CRW_PC_IRQ, 12'h000, 8'h00);
    chk({context_now, carry_flag, zero_flag}, 4'h4);
    go('0, '0, 3'b101);
    epc = epc + 12'h001;
    chk({carry_flag, zero_flag}, 2'b01);
    pc(crw_pkg::CRW_PC_RETURN_FROM_INTERRUPT, 12'h000, 8'h00);
    chk({context_now, carry_flag, zero_flag}, 4'hA);
    end_sim();
  end
endmodule
`default_nettype wire
